// ==== design/event_timer_map.vh ====
`ifndef EVENT_TIMER_MAP_VH
`define EVENT_TIMER_MAP_VH
// ----------------------------------------------------------------
// register byte offsets (one aligned word each)
// ----------------------------------------------------------------
`define OFS_COUNT0      8'h00
`define OFS_COUNT1      8'h04
`define OFS_THRESH0     8'h08
`define OFS_THRESH1     8'h0c
`define OFS_SRCSEL0     8'h10
`define OFS_SRCSEL1     8'h14
`define OFS_MODE0       8'h18
`define OFS_MODE1       8'h1c
`define OFS_COMBCOUNT   8'h20
`define OFS_COMBTHRESH  8'h24
`define OFS_STATUS      8'h28
// ----------------------------------------------------------------
// mode control fields
// ----------------------------------------------------------------
`define MODE_RUN_BIT    7
`define MODE_PWM_BIT    6
`define MODE_CHAIN_BIT  4
`define MODE_SET_BIT    3
`define MODE_CLR_BIT    2
`define MODE_TOG_BIT    1
`define MODE_OE_BIT     0
`define MODE_RW_MASK0   8'hc3
`define MODE_RW_MASK1   8'hd3
// ----------------------------------------------------------------
// count source codes
// ----------------------------------------------------------------
`define SRC_EV_FALL     3'h0
`define SRC_EV_RISE     3'h1
`define SRC_DIV1        3'h2
`define SRC_DIV2        3'h3
`define SRC_DIV4        3'h4
`define SRC_DIV64       3'h5
`define SRC_DIV256      3'h6
`define SRC_OTHER_IRQ   3'h7
// ----------------------------------------------------------------
// reset values and bus responses
// ----------------------------------------------------------------
`define RST_BYTE        8'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ==== design/timer_channel.v ====
`timescale 1ns/1ps
`default_nettype none
// one 8-bit counter with compare, output flip-flop and carry out
module timer_channel (
    input wire aclk,
    input wire aresetn,
    input wire tick,
    input wire run,
    input wire pwm,
    input wire tog_en,
    input wire low_active,
    input wire oe,
    input wire chained,
    input wire match_in,
    input wire match_sel,
    input wire lvl_set,
    input wire lvl_clr,
    input wire [7:0] threshold,
    output reg [7:0] count_ff,
    output wire carry,
    output wire match,
    output reg irq_ff,
    output reg pin_ff
);
    reg out_ff;
    reg [7:0] nxt_count;
    reg nxt_out;
    wire hit;
    assign carry = tick && run && (count_ff == 8'hff);
    assign match = (count_ff == threshold);
    // in chain mode the upper half only matches as part of the 16-bit value
    assign hit = match_sel ? match_in : match;
    always @* begin
        nxt_count = count_ff;
        nxt_out = out_ff;
        if (!run) begin
            nxt_count = 8'h00;
        end else if (tick) begin
            // a chained upper half also clears on the 16-bit match
            if (!pwm && hit) begin
                nxt_count = 8'h00;
            end else begin
                nxt_count = count_ff + 8'h01;
            end
        end
        if (pwm) begin
            if (!run) begin
                nxt_out = 1'b0;
            end else if (tick && count_ff == 8'hff) begin
                nxt_out = 1'b1;
            end else if (tick && match) begin
                nxt_out = 1'b0;
            end
        end else begin
            if (lvl_set && !lvl_clr) begin
                nxt_out = 1'b1;
            end else if (lvl_clr && !lvl_set) begin
                nxt_out = 1'b0;
            end else if (run && tick && hit && tog_en && !chained) begin
                nxt_out = ~out_ff;
            end
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_ff <= 8'h00;
            out_ff <= 1'b0;
            irq_ff <= 1'b0;
            pin_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            out_ff <= nxt_out;
            irq_ff <= run && tick && !pwm && hit && !chained;
            // disabled output is held low; pwm polarity follows the toggle bit
            pin_ff <= oe && (pwm ? (nxt_out ^ low_active) : nxt_out);
        end
    end
endmodule
`default_nettype wire

// ==== design/dual_8bit_event_timer_cascade.v ====
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_map.vh"
module dual_8bit_event_timer_cascade (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] event_input_pin,
    output reg [1:0] wave_output_pin,
    output reg [1:0] match_irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] match_threshold_ff [0:1];
    reg [2:0] count_source_select_ff [0:1];
    reg [7:0] channel_mode_control_ff [0:1];
    reg [1:0] lvl_set_ff;
    reg [1:0] lvl_clr_ff;
    reg [7:0] aw_addr_ff;
    reg aw_held_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg w_held_ff;
    reg [7:0] prescale_ff;
    reg [1:0] ev_sync1_ff;
    reg [1:0] ev_sync2_ff;
    reg [1:0] ev_prev_ff;
    wire [7:0] count [0:1];
    wire [1:0] carry;
    wire [1:0] match;
    wire [1:0] irq;
    wire [1:0] pin;
    wire [1:0] tick;
    wire [1:0] pre_tick;
    wire chain_on;
    wire match16;
    wire do_write;
    wire [7:0] prescale_next;
    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // only the upper channel owns the chain select bit
    assign chain_on = channel_mode_control_ff[1][`MODE_CHAIN_BIT];
    assign match16 = match[0] && match[1];
    assign prescale_next = prescale_ff + 8'h01;
    function src_tick;
        input [2:0] sel;
        input [7:0] pre_now;
        input [7:0] pre_nxt;
        input rise;
        input fall;
        input other;
        begin
            case (sel)
                `SRC_EV_FALL: src_tick = fall;
                `SRC_EV_RISE: src_tick = rise;
                `SRC_DIV1: src_tick = 1'b1;
                `SRC_DIV2: src_tick = pre_nxt[0] & ~pre_now[0];
                `SRC_DIV4: src_tick = pre_nxt[1] & ~pre_now[1];
                `SRC_DIV64: src_tick = pre_nxt[5] & ~pre_now[5];
                `SRC_DIV256: src_tick = (pre_now == 8'hff);
                `SRC_OTHER_IRQ: src_tick = other;
                default: src_tick = 1'b0;
            endcase
        end
    endfunction
    // ------------------------------------------------------------
    // count sources and channels
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            prescale_ff <= 8'h00;
            ev_sync1_ff <= 2'h0;
            ev_sync2_ff <= 2'h0;
            ev_prev_ff <= 2'h0;
        end else begin
            prescale_ff <= prescale_next;
            ev_sync1_ff <= event_input_pin;
            ev_sync2_ff <= ev_sync1_ff;
            ev_prev_ff <= ev_sync2_ff;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : chan
            wire run_bit;
            wire pwm_bit;
            // in chain mode the upper half runs only while both run bits are set; pwm is off in both halves
            assign run_bit = (gi == 1 && chain_on) ?
                (channel_mode_control_ff[0][`MODE_RUN_BIT] &&
                 channel_mode_control_ff[1][`MODE_RUN_BIT]) :
                channel_mode_control_ff[gi][`MODE_RUN_BIT];
            assign pwm_bit = channel_mode_control_ff[gi][`MODE_PWM_BIT] && !chain_on;
            assign pre_tick[gi] = src_tick(count_source_select_ff[gi], prescale_ff,
                prescale_next, ev_sync2_ff[gi] & ~ev_prev_ff[gi],
                ~ev_sync2_ff[gi] & ev_prev_ff[gi], irq[1 - gi]);
            // upper source select is ignored in chain mode; the extra term lets the
            // upper half see the tick on which the 16-bit match clears both halves
            assign tick[gi] = (gi == 1 && chain_on) ?
                (carry[0] || (tick[0] && match16 &&
                 channel_mode_control_ff[0][`MODE_RUN_BIT])) :
                pre_tick[gi];
            timer_channel u_ch (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick(tick[gi]),
                .run(run_bit),
                .pwm(pwm_bit),
                .tog_en(channel_mode_control_ff[gi][`MODE_TOG_BIT]),
                .low_active(channel_mode_control_ff[gi][`MODE_TOG_BIT]),
                .oe(channel_mode_control_ff[gi][`MODE_OE_BIT]),
                .chained(gi == 1 && chain_on),
                .match_in(match16),
                .match_sel(chain_on),
                .lvl_set(lvl_set_ff[gi]),
                .lvl_clr(lvl_clr_ff[gi]),
                .threshold(match_threshold_ff[gi]),
                .count_ff(count[gi]),
                .carry(carry[gi]),
                .match(match[gi]),
                .irq_ff(irq[gi]),
                .pin_ff(pin[gi])
            );
        end
    endgenerate
    // in chain mode the lower clear also resets upper via the shared match
    always @(posedge aclk) begin
        if (!aresetn) begin
            wave_output_pin <= 2'h0;
            match_irq <= 2'h0;
        end else begin
            wave_output_pin <= pin;
            match_irq <= irq;
        end
    end
    // ------------------------------------------------------------
    // axi4-lite write
    // ------------------------------------------------------------
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            lvl_set_ff <= 2'h0;
            lvl_clr_ff <= 2'h0;
            match_threshold_ff[0] <= `RST_BYTE;
            match_threshold_ff[1] <= `RST_BYTE;
            count_source_select_ff[0] <= 3'h0;
            count_source_select_ff[1] <= 3'h0;
            channel_mode_control_ff[0] <= `RST_BYTE;
            channel_mode_control_ff[1] <= `RST_BYTE;
        end else begin
            lvl_set_ff <= 2'h0;
            lvl_clr_ff <= 2'h0;
            s_axi_awready <= !aw_held_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                case (aw_addr_ff)
                    `OFS_THRESH0: if (w_strb_ff[0]) match_threshold_ff[0] <= w_data_ff[7:0];
                    `OFS_THRESH1: if (w_strb_ff[0]) match_threshold_ff[1] <= w_data_ff[7:0];
                    `OFS_SRCSEL0: if (w_strb_ff[0]) count_source_select_ff[0] <= w_data_ff[2:0];
                    `OFS_SRCSEL1: if (w_strb_ff[0]) count_source_select_ff[1] <= w_data_ff[2:0];
                    `OFS_MODE0: if (w_strb_ff[0]) begin
                        channel_mode_control_ff[0] <= w_data_ff[7:0] & `MODE_RW_MASK0;
                        lvl_set_ff[0] <= w_data_ff[`MODE_SET_BIT];
                        lvl_clr_ff[0] <= w_data_ff[`MODE_CLR_BIT];
                    end
                    `OFS_MODE1: if (w_strb_ff[0]) begin
                        channel_mode_control_ff[1] <= w_data_ff[7:0] & `MODE_RW_MASK1;
                        lvl_set_ff[1] <= w_data_ff[`MODE_SET_BIT];
                        lvl_clr_ff[1] <= w_data_ff[`MODE_CLR_BIT];
                    end
                    `OFS_COMBTHRESH: if (chain_on) begin
                        if (w_strb_ff[0]) match_threshold_ff[0] <= w_data_ff[7:0];
                        if (w_strb_ff[1]) match_threshold_ff[1] <= w_data_ff[15:8];
                    end else begin
                        s_axi_bresp <= `RESP_SLVERR;
                    end
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // axi4-lite read
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                case (s_axi_araddr)
                    `OFS_COUNT0: s_axi_rdata <= {24'h000000, count[0]};
                    `OFS_COUNT1: s_axi_rdata <= {24'h000000, count[1]};
                    `OFS_THRESH0: s_axi_rdata <= {24'h000000, match_threshold_ff[0]};
                    `OFS_THRESH1: s_axi_rdata <= {24'h000000, match_threshold_ff[1]};
                    `OFS_SRCSEL0: s_axi_rdata <= {29'h00000000, count_source_select_ff[0]};
                    `OFS_SRCSEL1: s_axi_rdata <= {29'h00000000, count_source_select_ff[1]};
                    // level field is never stored so it reads as zero
                    `OFS_MODE0: s_axi_rdata <= {24'h000000, channel_mode_control_ff[0]};
                    `OFS_MODE1: s_axi_rdata <= {24'h000000, channel_mode_control_ff[1]};
                    // both bytes captured on one edge so a word read is coherent
                    `OFS_COMBCOUNT: if (chain_on) begin
                        s_axi_rdata <= {16'h0000, count[1], count[0]};
                    end else begin
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                    `OFS_COMBTHRESH: if (chain_on) begin
                        s_axi_rdata <= {16'h0000, match_threshold_ff[1], match_threshold_ff[0]};
                    end else begin
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                    `OFS_STATUS: s_axi_rdata <= {24'h000000, 2'h0, wave_output_pin,
                        2'h0, match};
                    default: s_axi_rresp <= `RESP_SLVERR;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/event_timer_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module event_timer_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] match_irq,
    input wire logic [1:0] wave_output_pin
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    property p_aw_pulse; s_axi_awready |-> s_axi_awvalid ##1 !s_axi_awready; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready without request");
    property p_b_after; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
    a_b_after: assert property (p_b_after) else $error("write response late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_after: assert property (p_r_after) else $error("read data late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_drop: assert property (p_r_drop) else $error("read data repeated");
    // ----------------------------------------------------------------
    // timer outputs
    // ----------------------------------------------------------------
    property p_irq0_pulse; match_irq[0] |=> !match_irq[0]; endproperty
    a_irq0_pulse: assert property (p_irq0_pulse) else $error("lower irq not a pulse");
    property p_irq1_pulse; match_irq[1] |=> !match_irq[1]; endproperty
    a_irq1_pulse: assert property (p_irq1_pulse) else $error("upper irq not a pulse");
    property p_rst_quiet; $rose(aresetn) |-> wave_output_pin == 2'h0 && match_irq == 2'h0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
endmodule
`default_nettype wire

// ==== bench/event_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// event source and output load; pulses are wide enough for the input synchroniser
module event_load_model (
    input wire logic aclk,
    input wire logic [1:0] wave_output_pin,
    output logic [1:0] event_input_pin
);
    initial event_input_pin = 2'h0;
    task automatic pulses(input int ch, input int n);
        repeat (n) begin
            @(posedge aclk);
            event_input_pin[ch] <= 1'b1;
            repeat (4) @(posedge aclk);
            event_input_pin[ch] <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
    task automatic duty(input int ch, input int cyc, output int h);
        h = 0;
        repeat (cyc) begin
            @(posedge aclk);
            if (wave_output_pin[ch] === 1'b1) h++;
        end
    endtask
endmodule
`default_nettype wire

// ==== bench/dual_8bit_event_timer_cascade_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "event_timer_map.vh"
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module dual_8bit_event_timer_cascade_tb;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, wave_output_pin, match_irq, event_input_pin;
    logic [31:0] s_axi_rdata;
    logic [65:0] exp_e;
    logic [65:0] exp_q[$];
    int fails = 0, compares = 0, up_irqs = 0;
    always #20 aclk = ~aclk;
    dual_8bit_event_timer_cascade DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .event_input_pin(event_input_pin), .wave_output_pin(wave_output_pin),
        .match_irq(match_irq));
    event_load_model u_load (.aclk(aclk), .wave_output_pin(wave_output_pin),
        .event_input_pin(event_input_pin));
    task automatic stop_test();
        if (fails == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // response watcher: each answer is matched against the oldest note
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (match_irq[1] === 1'b1) up_irqs++;
        if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
            exp_e = exp_q.pop_front();
            `CHK("resp", exp_e[65:64], s_axi_rvalid ? s_axi_rresp : s_axi_bresp)
            `CHK("rdata", exp_e[63:32], s_axi_rdata & exp_e[31:0])
        end
    end
    // ----------------------------------------------------------------
    // bus tasks: one edge first so no signal is assigned twice per step
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        exp_q.push_back({er, 64'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 60);
        s_axi_bready <= 1'b0;
        if (n >= 60) begin fails++; stop_test(); end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
            input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        exp_q.push_back({er, d & m, m});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 60);
        s_axi_rready <= 1'b0;
        if (n >= 60) begin fails++; stop_test(); end
    endtask
    task automatic w8(input logic [7:0] a, input logic [7:0] v);
        wr(a, {24'h0, v}, 4'h1, `RESP_OKAY);
    endtask
    task automatic r8(input logic [7:0] a, input logic [7:0] v);
        rd(a, {24'h0, v}, 32'hff, `RESP_OKAY);
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (match_irq[0] !== 1'b1 && n < 2000);
        if (n >= 2000) begin fails++; stop_test(); end
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int n, p, q, thr;
        logic [7:0] v;
        logic a_pin;
        void'($urandom(32'h67c2));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        r8(`OFS_COUNT0, `RST_BYTE);
        r8(`OFS_THRESH1, `RST_BYTE);
        r8(`OFS_MODE1, `RST_BYTE);
        wr(`OFS_COUNT1, 32'hff, 4'h1, `RESP_SLVERR);
        wr(`OFS_COMBTHRESH, 32'h1234, 4'h3, `RESP_SLVERR);
        rd(8'h2c, 32'h0, 32'hffffffff, `RESP_SLVERR);
        for (int i = 0; i < 6; i++) begin
            v = (i < 2) ? 8'h00 : (i < 4) ? 8'hff : 8'($urandom);
            w8(`OFS_THRESH0 + 8'(4 * (i % 2)), v);
            r8(`OFS_THRESH0 + 8'(4 * (i % 2)), v);
        end
        for (int i = 0; i < 8; i++) begin
            w8(`OFS_SRCSEL1, 8'(i));
            r8(`OFS_SRCSEL1, 8'(i));
        end
        // interval timing on three dividers; stopped before every change
        thr = 5 + $urandom % 8;
        w8(`OFS_THRESH0, 8'(thr));
        for (int i = 0; i < 3; i++) begin
            w8(`OFS_MODE0, 8'h00);
            w8(`OFS_SRCSEL0, 8'(`SRC_DIV1 + i));
            w8(`OFS_MODE0, 8'h80);
            wait_irq(n);
            wait_irq(n);
            `CHK("interval", (thr + 1) << i, n)
        end
        // upper counts lower match pulses; window is aligned just after a lower pulse
        w8(`OFS_THRESH1, 8'h01);
        w8(`OFS_MODE1, 8'h80);
        wait_irq(n);
        up_irqs = 0;
        repeat (16 * (thr + 1)) @(posedge aclk);
        `CHK("other irq", 2, up_irqs)
        w8(`OFS_MODE0, 8'h00);
        r8(`OFS_COUNT0, 8'h00);
        w8(`OFS_SRCSEL0, 8'(`SRC_DIV1));
        w8(`OFS_MODE0, 8'h83);
        wait_irq(n);
        repeat (3) @(posedge aclk);
        a_pin = wave_output_pin[0];
        wait_irq(n);
        repeat (3) @(posedge aclk);
        `CHK("toggle", ~a_pin, wave_output_pin[0])
        w8(`OFS_MODE0, 8'h09);
        repeat (3) @(posedge aclk);
        `CHK("set", 1'b1, wave_output_pin[0])
        r8(`OFS_MODE0, 8'h01);
        w8(`OFS_MODE0, 8'h08);
        repeat (3) @(posedge aclk);
        `CHK("oe off", 1'b0, wave_output_pin[0])
        w8(`OFS_MODE0, 8'h05);
        repeat (3) @(posedge aclk);
        `CHK("clear", 1'b0, wave_output_pin[0])
        thr = 20 + $urandom % 180;
        w8(`OFS_THRESH0, 8'(thr));
        w8(`OFS_MODE0, 8'hc1);
        repeat (300) @(posedge aclk);
        u_load.duty(0, 256, p);
        `CHK("pwm high", thr + 1, p)
        w8(`OFS_MODE0, 8'hc3);
        repeat (4) @(posedge aclk);
        u_load.duty(0, 256, q);
        `CHK("pwm low", 255 - thr, q)
        for (int c = 0; c < 2; c++) for (int e = 0; e < 2; e++) begin
            w8(`OFS_MODE0 + 8'(4 * c), 8'h00);
            w8(`OFS_THRESH0 + 8'(4 * c), 8'hff);
            w8(`OFS_SRCSEL0 + 8'(4 * c), 8'(`SRC_EV_FALL + e));
            w8(`OFS_MODE0 + 8'(4 * c), 8'h80);
            u_load.pulses(c, 3 + e);
            repeat (6) @(posedge aclk);
            r8(`OFS_COUNT0 + 8'(4 * c), 8'(3 + e));
        end
        w8(`OFS_MODE1, 8'h09);
        repeat (3) @(posedge aclk);
        `CHK("set1", 1'b1, wave_output_pin[1])
        r8(`OFS_STATUS, 8'h20);
        // cascade: both stopped before the combined threshold changes
        w8(`OFS_MODE0, 8'h00);
        w8(`OFS_MODE1, 8'h00);
        w8(`OFS_SRCSEL0, 8'(`SRC_DIV1));
        w8(`OFS_MODE1, 8'h10);
        wr(`OFS_COMBTHRESH, 32'h0140, 4'h3, `RESP_OKAY);
        rd(`OFS_COMBTHRESH, 32'h0140, 32'hffff, `RESP_OKAY);
        w8(`OFS_MODE1, 8'h90);
        up_irqs = 0;
        w8(`OFS_MODE0, 8'h80);
        repeat (280) @(posedge aclk);
        rd(`OFS_COMBCOUNT, 32'h0100, 32'hff00, `RESP_OKAY);
        rd(`OFS_COMBCOUNT, 32'h0100, 32'hff00, `RESP_OKAY);
        wait_irq(n);
        `CHK("chain match", 1'b1, n < 80)
        `CHK("upper irq", 0, up_irqs)
        rd(`OFS_COMBCOUNT, 32'h0, 32'hff00, `RESP_OKAY);
        w8(`OFS_MODE0, 8'h00);
        rd(`OFS_COMBCOUNT, 32'h0, 32'hffff, `RESP_OKAY);
        r8(`OFS_COUNT1, 8'h00);
        stop_test();
    end
endmodule
bind dual_8bit_event_timer_cascade event_timer_sva u_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .match_irq(match_irq), .wave_output_pin(wave_output_pin));
`default_nettype wire
